// File: verilog/time_quality_alarm.sv
`timescale 1ns/1ns
module time_quality_alarm
  import time_quality_pkg::*;
#(
  parameter int ALARM_SECS = ALARM_SECONDS
) (
  // Clock and synchronous reset.
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // Reference status and measurement.
  input  wire logic        tick_1s_i,
  input  wire logic        locked_i,
  input  wire logic [31:0] err_meas_i,
  // AHB-Lite slave.
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Status outputs.
  output logic [3:0]       time_quality_code_o,
  output logic             alarm_led_o,
  output logic             los_fault_o,
  output logic             irq_o
);

  // ==========================================================
  // State
  // All state in one record; the comb process builds the next copy.
  typedef struct packed {
    logic [3:0]  code;      // Reported quality code.
    logic        ever;      // Reference was locked at least once.
    logic        coast;     // Running on extrapolation.
    logic [31:0] est;       // Current error estimate in ns.
    logic [3:0]  thresh;    // Alarm threshold code.
    logic [31:0] drift;     // Worst-case drift in ns per second.
    logic [11:0] secs;      // Seconds spent at or past threshold.
    logic        alarm;     // Loss-of-signal alarm.
    logic [1:0]  istat;     // Sticky interrupt events.
    logic [1:0]  imask;     // Interrupt enables.
    logic        irq;       // Registered interrupt line.
    logic        dvalid;    // A write data phase is pending.
    logic [4:0]  daddr;     // Address of the pending write.
    logic [31:0] rdata;     // Read data for the data phase.
  } state_t;

  state_t cur_ff;  // Registered state.
  state_t nxt_st;  // Next state.

  // Maps an error in ns onto its quality code.
  function automatic logic [3:0] quality_of(input logic [31:0] e);
    if (e < BOUND_1US) begin
      quality_of = CODE_BEST;
    end else if (e < BOUND_10US) begin
      quality_of = 4'h5;
    end else if (e < BOUND_100US) begin
      quality_of = 4'h6;
    end else if (e < BOUND_1MS) begin
      quality_of = 4'h7;
    end else if (e < BOUND_10MS) begin
      quality_of = 4'h8;
    end else begin
      quality_of = CODE_WORST;
    end
  endfunction

  logic        addr_ph;  // Address phase taken this cycle.
  logic [3:0]  calc;     // Code from the current estimate.
  logic [32:0] sum;      // Estimate plus one second of drift.

  assign addr_ph = hsel_i && htrans_i[1] && hready_i;

  // ==========================================================
  // Next-state logic
  // Register writes land first so a read right behind sees them.
  always_comb begin
    nxt_st = cur_ff;
    sum    = {1'b0, cur_ff.est} + {1'b0, cur_ff.drift};
    calc   = CODE_WORST;

    // Write data phase of the previous transfer.
    nxt_st.dvalid = addr_ph && hwrite_i;
    nxt_st.daddr  = haddr_i[4:0];
    if (cur_ff.dvalid) begin
      case (cur_ff.daddr)
        OFS_THRESH: begin
          nxt_st.thresh = hwdata_i[3:0];
        end
        OFS_DRIFT: begin
          nxt_st.drift = hwdata_i;
        end
        OFS_IRQ_MASK: begin
          nxt_st.imask = hwdata_i[1:0];
        end
        OFS_IRQ_STAT: begin
          nxt_st.istat = cur_ff.istat & ~hwdata_i[1:0];
        end
        default: begin
          nxt_st.drift = cur_ff.drift;
        end
      endcase
    end

    // Error estimate: measured when locked, grown while coasting.
    if (locked_i) begin
      nxt_st.ever  = 1'b1;
      nxt_st.coast = 1'b0;
      nxt_st.est   = err_meas_i;
    end else if (cur_ff.ever) begin
      nxt_st.coast = 1'b1;
      if (tick_1s_i) begin
        // Saturate rather than wrap, so a long outage stays worst.
        nxt_st.est = sum[32] ? 32'hFFFF_FFFF : sum[31:0];
      end
    end

    // Quality code; the threshold plays no part here.
    if (!nxt_st.ever) begin
      nxt_st.code = CODE_WORST;
    end else begin
      calc = quality_of(nxt_st.est);
      if (nxt_st.coast && calc > cur_ff.code) begin
        nxt_st.code = cur_ff.code + 4'h1;
      end else begin
        nxt_st.code = calc;
      end
    end

    // One-hour timer against the threshold.
    if (cur_ff.code < cur_ff.thresh) begin
      nxt_st.secs  = 12'h000;
      nxt_st.alarm = 1'b0;
    end else if (tick_1s_i) begin
      if (cur_ff.secs == 12'(ALARM_SECS - 1)) begin
        nxt_st.alarm = 1'b1;
      end else begin
        nxt_st.secs = cur_ff.secs + 12'h001;
      end
    end

    // Events win over a clear in the same cycle.
    if (nxt_st.code != cur_ff.code) begin
      nxt_st.istat[IRQ_CHANGE] = 1'b1;
    end
    if (nxt_st.alarm && !cur_ff.alarm) begin
      nxt_st.istat[IRQ_ALARM] = 1'b1;
    end
    nxt_st.irq = |(nxt_st.istat & nxt_st.imask);

    // Read data, taken from the next state so it is current.
    nxt_st.rdata = 32'h0000_0000;
    if (addr_ph && !hwrite_i) begin
      case (haddr_i[4:0])
        OFS_CODE: begin
          nxt_st.rdata[3:0]      = nxt_st.code;
          nxt_st.rdata[POS_EVER]  = nxt_st.ever;
          nxt_st.rdata[POS_COAST] = nxt_st.coast;
        end
        OFS_THRESH: begin
          nxt_st.rdata[3:0] = nxt_st.thresh;
        end
        OFS_FAULT: begin
          nxt_st.rdata[0] = nxt_st.alarm;
        end
        OFS_DRIFT: begin
          nxt_st.rdata = nxt_st.drift;
        end
        OFS_IRQ_STAT: begin
          nxt_st.rdata[1:0] = nxt_st.istat;
        end
        OFS_IRQ_MASK: begin
          nxt_st.rdata[1:0] = nxt_st.imask;
        end
        OFS_EST_ERR: begin
          nxt_st.rdata = nxt_st.est;
        end
        default: begin
          nxt_st.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  // Synchronous reset; threshold comes up at nine.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cur_ff        <= '0;
      cur_ff.code   <= CODE_WORST;
      cur_ff.thresh <= THRESH_RST;
      cur_ff.drift  <= DRIFT_RST;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // Outputs come straight from state flops.
  assign time_quality_code_o = cur_ff.code;
  assign alarm_led_o         = cur_ff.alarm;
  assign los_fault_o         = cur_ff.alarm;
  assign irq_o               = cur_ff.irq;
  assign hrdata_o            = cur_ff.rdata;
  // Zero wait states and always OKAY.
  assign hreadyout_o         = 1'b1;
  assign hresp_o             = 1'b0;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_thresh_wr;
    addr_ph && hwrite_i && haddr_i[4:0] == OFS_THRESH;
  endsequence

  property p_code_range;
    cur_ff.code >= CODE_BEST && cur_ff.code <= CODE_WORST;
  endproperty
  a_code_range: assert property (p_code_range) else $error("code out of range");

  property p_meas_code;
    locked_i |=> cur_ff.code == quality_of($past(err_meas_i));
  endproperty
  a_meas_code: assert property (p_meas_code) else $error("code does not match error");

  property p_never_nine;
    !cur_ff.ever |-> cur_ff.code == CODE_WORST;
  endproperty
  a_never_nine: assert property (p_never_nine) else $error("unlocked code not nine");

  property p_coast_grow;
    cur_ff.coast && tick_1s_i && !locked_i |=> cur_ff.est >= $past(cur_ff.est);
  endproperty
  a_coast_grow: assert property (p_coast_grow) else $error("estimate shrank in coast");

  property p_step;
    cur_ff.coast && !locked_i |=> cur_ff.code <= $past(cur_ff.code) + 4'h1;
  endproperty
  a_step: assert property (p_step) else $error("code jumped more than one");

  property p_alarm_time;
    $rose(cur_ff.alarm) |-> $past(tick_1s_i) && $past(cur_ff.secs) == 12'(ALARM_SECS - 1);
  endproperty
  a_alarm_time: assert property (p_alarm_time) else $error("alarm before timeout");

  property p_fault_bit;
    los_fault_o == alarm_led_o;
  endproperty
  a_fault_bit: assert property (p_fault_bit) else $error("fault bit differs from led");

  // A read of the fault word must show the same bit that the pin shows.
  property p_fault_read;
    addr_ph && !hwrite_i && haddr_i[4:0] == OFS_FAULT |=> hrdata_o[0] == los_fault_o;
  endproperty
  a_fault_read: assert property (p_fault_read) else $error("fault word differs from pin");

  property p_thresh_wr;
    s_thresh_wr ##1 1'b1 |=> cur_ff.thresh == $past(hwdata_i[3:0]);
  endproperty
  a_thresh_wr: assert property (p_thresh_wr) else $error("threshold write lost");

  property p_thresh_rst;
    @(posedge mclk_i) disable iff (1'b0) $past(rst_i) |-> cur_ff.thresh == THRESH_RST;
  endproperty
  a_thresh_rst: assert property (p_thresh_rst) else $error("threshold reset not nine");

  property p_below_clear;
    cur_ff.code < cur_ff.thresh |=> !cur_ff.alarm && cur_ff.secs == 12'h000;
  endproperty
  a_below_clear: assert property (p_below_clear) else $error("alarm kept below threshold");

  // Once raised, the alarm holds as long as the code stays at or past the threshold.
  property p_alarm_hold;
    cur_ff.alarm && cur_ff.code >= cur_ff.thresh |=> cur_ff.alarm;
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped at threshold");

  // A new code must leave its sticky event bit set, even when a clear lands in the same cycle.
  property p_change_irq;
    cur_ff.code != $past(cur_ff.code) |-> cur_ff.istat[IRQ_CHANGE];
  endproperty
  a_change_irq: assert property (p_change_irq) else $error("code change not flagged");

  property p_irq;
    irq_o == |(cur_ff.istat & cur_ff.imask);
  endproperty
  a_irq: assert property (p_irq) else $error("irq does not follow status");

endmodule

// File: verilog/time_quality_pkg.sv
// ==========================================================
// Constants shared by the time-quality block.
package time_quality_pkg;
  // Quality codes, best and worst.
  localparam logic [3:0]  CODE_BEST     = 4'h4;
  localparam logic [3:0]  CODE_WORST    = 4'h9;
  // Error bounds in nanoseconds for codes 4 to 8.
  localparam logic [31:0] BOUND_1US     = 32'h0000_03E8;
  localparam logic [31:0] BOUND_10US    = 32'h0000_2710;
  localparam logic [31:0] BOUND_100US   = 32'h0001_86A0;
  localparam logic [31:0] BOUND_1MS     = 32'h000F_4240;
  localparam logic [31:0] BOUND_10MS    = 32'h0098_9680;
  // Alarm delay in seconds (one hour) and reset values.
  localparam int          ALARM_SECONDS = 3600;
  localparam logic [3:0]  THRESH_RST    = 4'h9;
  localparam logic [31:0] DRIFT_RST     = 32'h0000_0064;
  // Register byte offsets.
  localparam logic [4:0]  OFS_CODE      = 5'h00;
  localparam logic [4:0]  OFS_THRESH    = 5'h04;
  localparam logic [4:0]  OFS_FAULT     = 5'h08;
  localparam logic [4:0]  OFS_DRIFT     = 5'h0C;
  localparam logic [4:0]  OFS_IRQ_STAT  = 5'h10;
  localparam logic [4:0]  OFS_IRQ_MASK  = 5'h14;
  localparam logic [4:0]  OFS_EST_ERR   = 5'h18;
  // Field positions.
  localparam int          POS_EVER      = 8;
  localparam int          POS_COAST     = 9;
  localparam int          IRQ_CHANGE    = 0;
  localparam int          IRQ_ALARM     = 1;
  // AHB transfer type with bit 1 set means a real transfer.
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
endpackage

// File: tb/tb_top.sv
`timescale 1ns/1ns
// ==========================================
// Self-checking bench for the time-quality alarm block.
module tb_top import time_quality_pkg::*;;
  // Design inputs, all given a value at time zero.
  logic        mclk_i = 1'b0, rst_i = 1'b1, tick_1s_i = 1'b0, locked_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
  logic [31:0] err_meas_i = 32'h0000_0000, haddr_i = 32'h0000_0000, hwdata_i = 32'h0000_0000;
  logic [1:0]  htrans_i = 2'h0;
  logic [2:0]  hsize_i = 3'h2;
  // Design outputs and bench scratch values.
  logic [31:0] hrdata_o, rd, e;
  logic        hreadyout_o, hresp_o, alarm_led_o, los_fault_o, irq_o;
  logic [3:0]  time_quality_code_o, prev_code;
  logic [31:0] bnd [5] = '{BOUND_1US, BOUND_10US, BOUND_100US, BOUND_1MS, BOUND_10MS};
  int          num_errors = 0, comparisons = 0, cycles = 0, seed = 32'ha13b19ed;

  // A short alarm delay keeps the hour-long wait to four ticks.
  time_quality_alarm #(.ALARM_SECS(4)) i_time_quality_alarm (
    .mclk_i(mclk_i), .rst_i(rst_i), .tick_1s_i(tick_1s_i), .locked_i(locked_i), .err_meas_i(err_meas_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .time_quality_code_o(time_quality_code_o), .alarm_led_o(alarm_led_o),
    .los_fault_o(los_fault_o), .irq_o(irq_o));

  // ==========================================
  // Clock, timeout and the coasting step monitor.
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end
  // The design updates on non-blocking edges, so pre-edge values are read here.
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    prev_code <= time_quality_code_o;
    if (!rst_i && !locked_i && time_quality_code_o > prev_code + 4'h1) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, time_quality_code_o, prev_code + 4'h1);
    end
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  // ==========================================
  // Helpers.
  // Expected code from an error in nanoseconds.
  function automatic logic [3:0] exp_code(input logic [31:0] err);
    for (int k = 0; k < 5; k++) begin
      if (err < bnd[k]) return CODE_BEST + 4'(k);
    end
    return CODE_WORST;
  endfunction
  // Compare and count.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One single AHB-Lite word transfer; read data is taken at the data-phase edge.
  task automatic bus(input logic wr, input logic [4:0] ofs, input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge mclk_i);
    hsel_i <= 1'b1;
    haddr_i <= {27'h000_0000, ofs};
    htrans_i <= HTRANS_NONSEQ;
    hwrite_i <= wr;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    rdat = hrdata_o;
    chk({31'h0, hresp_o}, 32'h0000_0000);
  endtask
  // Apply a reference state and let the code settle.
  task automatic setin(input logic lk, input logic [31:0] err);
    @(posedge mclk_i);
    locked_i <= lk;
    err_meas_i <= err;
    repeat (8) @(posedge mclk_i);
  endtask
  // One-second tick, a single cycle wide.
  task automatic tick();
    @(posedge mclk_i);
    tick_1s_i <= 1'b1;
    @(posedge mclk_i);
    tick_1s_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================
  // Main sequence.
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    bus(1'b0, OFS_THRESH, 32'h0000_0000, rd);
    chk(rd, {28'h000_0000, THRESH_RST});
    bus(1'b0, OFS_CODE, 32'h0000_0000, rd);
    chk(rd & 32'h0000_010F, 32'h0000_0009);
    bus(1'b0, 5'h1C, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    bus(1'b1, OFS_THRESH, 32'h0000_0007, rd);
    bus(1'b0, OFS_THRESH, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0007);
    // Boundary errors on both sides of each bound, then random magnitudes.
    for (int i = 0; i < 50; i++) begin
      e = $random(seed);
      e = e >> ($unsigned($random(seed)) % 32);
      if (i < 10) e = bnd[i / 2] - {31'h0000_0000, ~i[0]};
      setin(1'b1, e);
      chk({28'h000_0000, time_quality_code_o}, {28'h000_0000, exp_code(e)});
    end
    // Alarm after the delay at code 7 with threshold 7, then release.
    setin(1'b1, 32'h0007_A120);
    bus(1'b1, OFS_IRQ_MASK, 32'h0000_0002, rd);
    bus(1'b1, OFS_IRQ_STAT, 32'h0000_0003, rd);
    repeat (3) tick();
    chk({31'h0, alarm_led_o}, 32'h0000_0000);
    tick();
    chk({31'h0, alarm_led_o}, 32'h0000_0001);
    chk({31'h0, irq_o}, 32'h0000_0001);
    bus(1'b0, OFS_FAULT, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0001);
    chk({28'h000_0000, time_quality_code_o}, 32'h0000_0007);
    setin(1'b1, 32'h0000_1388);
    chk({30'h0, alarm_led_o, los_fault_o}, 32'h0000_0000);
    bus(1'b1, OFS_IRQ_STAT, 32'h0000_0003, rd);
    // The clear and the registered line both update on the last bus edge; the check waits one more edge to see it.
    @(posedge mclk_i);
    chk({31'h0, irq_o}, 32'h0000_0000);
    // Coasting: estimate grows by the drift per tick.
    setin(1'b1, 32'h0000_0000);
    bus(1'b1, OFS_DRIFT, 32'h0000_0BB8, rd);
    setin(1'b0, 32'h0000_0000);
    for (int k = 1; k <= 5; k++) begin
      tick();
      bus(1'b0, OFS_EST_ERR, 32'h0000_0000, rd);
      chk(rd, 32'(k * 3000));
      chk({28'h000_0000, time_quality_code_o}, {28'h000_0000, exp_code(32'(k * 3000))});
    end
    // A big drift pushes the estimate past 10 ms; the monitor checks one step per cycle.
    bus(1'b1, OFS_DRIFT, BOUND_10MS, rd);
    tick();
    bus(1'b0, OFS_EST_ERR, 32'h0000_0000, rd);
    chk(rd, BOUND_10MS + 32'(5 * 3000));
    chk({28'h000_0000, time_quality_code_o}, 32'h0000_0009);
    // Code-change events are sticky and reach the line once masked in.
    bus(1'b1, OFS_IRQ_MASK, 32'h0000_0001, rd);
    @(posedge mclk_i);
    chk({31'h0, irq_o}, 32'h0000_0001);
    bus(1'b0, OFS_IRQ_STAT, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0001);
    bus(1'b0, OFS_CODE, 32'h0000_0000, rd);
    chk(rd & 32'h0000_0300, 32'h0000_0300);
    report_and_stop();
  end
endmodule
